// file: logic/pdmc_top.sv
// Purpose: power-down mode control: sleep, software standby, module stop
// Assumes: cpu gives a one-cycle sleep pulse; wake sources are pins
// Notes: clock gating is shown as per-module clock enables
`timescale 1ns/1ps
module pdmc_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // reset pins, active low
    input wire logic poweron_reset_pin_n,
    input wire logic manual_reset_pin_n,
    // cpu side
    input wire logic sleep_exec,
    input wire logic cpu_block_bit,
    input wire logic [3:0] interrupt_mask_field,
    // standby control register writes
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_wdata,
    input wire logic ctrl2_wr,
    input wire logic [7:0] ctrl2_wdata,
    // watchdog programming
    input wire logic wdog_wr,
    input wire logic [7:0] wdog_wdata,
    input wire logic [2:0] wdog_clock_select,
    // wake sources
    input wire logic nmi_pin,
    input wire logic [3:0] encoded_level_lines,
    input wire logic [4:0] external_irq_lines,
    input wire logic periph_irq,
    input wire logic rtc_irq,
    input wire logic timer_irq,
    input wire logic timer_on_rtc_clk,
    // register read back
    output logic [7:0] standby_control_reg,
    output logic [7:0] standby_control_reg_two,
    output logic [7:0] wdog_counter,
    // state pins
    output logic state_out_upper,
    output logic state_out_lower,
    // cpu and clock control
    output logic cpu_halt,
    output logic cpu_clk_en,
    output logic clock_out_en,
    output logic intr_start,
    output logic [11:0] event_code_reg,
    output logic [11:0] event_code_reg_two,
    // module clock enables and resets
    output logic [7:0] mod_clk_en,
    output logic timer_start_clr,
    output logic adc_regs_reset,
    output logic timer_regs_reset,
    output logic serial_pins_reset
);
    logic por_s_n, man_s_n, nmi_s, periph_s, rtc_s, tmr_s;
    logic [3:0] irl_s;
    logic [4:0] irq_s;
    logic pin_reset;
    pdmc_pkg::pdmc_state_t state_ff;
    logic [7:0] ctrl_ff, ctrl2_ff;
    logic wd_done;
    logic [7:0] wd_count;
    logic irl_wake, any_int, standby_select_bit_wake;
    logic [11:0] nxt_code;
    logic reset_seen_ff;
    logic wd_done_q_ff;
    logic [3:0] irl_lvl;
    localparam pdmc_pkg::pdmc_state_t ST_RUN = pdmc_pkg::ST_RUN;
    localparam pdmc_pkg::pdmc_state_t ST_SLEEP = pdmc_pkg::ST_SLEEP;
    localparam pdmc_pkg::pdmc_state_t ST_STANDBY = pdmc_pkg::ST_STANDBY;
    localparam pdmc_pkg::pdmc_state_t ST_SETTLE = pdmc_pkg::ST_SETTLE;

    // reset to idle pin levels: no false reset or wake after rst
    pdmc_sync #(.W(15), .INIT(15'h61e0)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({poweron_reset_pin_n, manual_reset_pin_n, nmi_pin, periph_irq, rtc_irq,
            timer_irq, encoded_level_lines, external_irq_lines}),
        .q({por_s_n, man_s_n, nmi_s, periph_s, rtc_s, tmr_s, irl_s, irq_s})
    );

    // either reset pin low ends sleep and standby
    assign pin_reset = !por_s_n || !man_s_n;

    assign irl_lvl = ~irl_s;
    // level wake only above mask; block bit not consulted
    assign irl_wake = (irl_s != pdmc_pkg::IRL_NONE) &&
                      ((~irl_s) > interrupt_mask_field);
    assign any_int = nmi_s || irl_wake || (|irq_s) || periph_s || rtc_s || tmr_s;
    assign standby_select_bit_wake = nmi_s || irl_wake || (|irq_s) || rtc_s ||
                       (tmr_s && timer_on_rtc_clk);

    // source code, nmi highest priority
    always_comb begin
        nxt_code = pdmc_pkg::EVT_PERIPH;
        if (nmi_s) begin
            nxt_code = pdmc_pkg::EVT_NMI;
        end else if (irl_wake) begin
            nxt_code = 12'(pdmc_pkg::EVT_IRL_BASE + 12'(irl_lvl) * pdmc_pkg::EVT_STEP);
        end else begin
            for (int i = 4; i >= 0; i--) begin
                if (irq_s[i]) begin
                    nxt_code = 12'(pdmc_pkg::EVT_IRQ_BASE + 12'(i) * pdmc_pkg::EVT_STEP);
                end
            end
        end
    end

    // control registers; reserved bits masked off
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_ff <= pdmc_pkg::CTRL_RESET;
            ctrl2_ff <= pdmc_pkg::CTRL_RESET;
        end else if (pin_reset) begin
            ctrl_ff <= pdmc_pkg::CTRL_RESET;
            ctrl2_ff <= pdmc_pkg::CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_ff <= ctrl_wdata & pdmc_pkg::CTRL_WMASK;
            end
            if (ctrl2_wr) begin
                ctrl2_ff <= ctrl2_wdata & pdmc_pkg::CTRL2_WMASK;
            end
        end
    end

    pdmc_wdog u_wdog (
        .clk_sys(clk_sys),
        .rst(rst),
        .run((state_ff == ST_SETTLE) || (state_ff == ST_RUN && ctrl_ff[pdmc_pkg::STANDBY_SELECT_BIT_BIT]
              && reset_seen_ff)),
        .load(wdog_wr),
        .load_val(wdog_wdata),
        .clk_sel(wdog_clock_select),
        .count_ff(wd_count),
        .done(wd_done)
    );

    // marks a standby exit with standby select still set
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reset_seen_ff <= 1'b0;
        end else if (pin_reset || !ctrl_ff[pdmc_pkg::STANDBY_SELECT_BIT_BIT] || wdog_wr) begin
            reset_seen_ff <= 1'b0;
        end else if (state_ff == ST_SETTLE && wd_done) begin
            reset_seen_ff <= 1'b1;
        end
    end

    // rising done marks the counter wrapping back to 80h
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wd_done_q_ff <= 1'b0;
        end else begin
            wd_done_q_ff <= wd_done;
        end
    end

    // power state machine
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= ST_RUN;
        end else if (pin_reset) begin
            state_ff <= ST_RUN;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (sleep_exec && !ctrl_ff[pdmc_pkg::STANDBY_SELECT_BIT_BIT]) begin
                        state_ff <= ST_SLEEP;
                    end else if (sleep_exec || (reset_seen_ff && wd_done && !wd_done_q_ff)) begin
                        state_ff <= ST_STANDBY;
                    end
                end
                ST_SLEEP: begin
                    if (any_int) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_STANDBY: begin
                    if (standby_select_bit_wake) begin
                        state_ff <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (wd_done) begin
                        state_ff <= ST_RUN;
                    end
                end
                default: begin
                    state_ff <= ST_RUN;
                end
            endcase
        end
    end

    // state pins and cpu/clock enables
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            {state_out_upper, state_out_lower} <= pdmc_pkg::PINS_RESET;
            cpu_halt <= 1'b1;
            cpu_clk_en <= 1'b0;
            clock_out_en <= 1'b1;
        end else if (pin_reset) begin
            {state_out_upper, state_out_lower} <= pdmc_pkg::PINS_RESET;
            cpu_halt <= 1'b1;
            cpu_clk_en <= 1'b1;
            clock_out_en <= 1'b1;
        end else begin
            case (state_ff)
                ST_SLEEP: begin
                    {state_out_upper, state_out_lower} <= pdmc_pkg::PINS_SLEEP;
                    cpu_halt <= 1'b1;
                    cpu_clk_en <= 1'b1;
                    clock_out_en <= 1'b1;
                end
                ST_STANDBY, ST_SETTLE: begin
                    {state_out_upper, state_out_lower} <= pdmc_pkg::PINS_STANDBY;
                    cpu_halt <= 1'b1;
                    cpu_clk_en <= 1'b0;
                    clock_out_en <= 1'b0;
                end
                default: begin
                    {state_out_upper, state_out_lower} <= pdmc_pkg::PINS_NORMAL;
                    cpu_halt <= 1'b0;
                    cpu_clk_en <= 1'b1;
                    clock_out_en <= 1'b1;
                end
            endcase
        end
    end

    // exception start and event codes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            intr_start <= 1'b0;
            event_code_reg <= '0;
            event_code_reg_two <= '0;
        end else begin
            intr_start <= 1'b0;
            if (!pin_reset && ((state_ff == ST_SLEEP && any_int) ||
                               (state_ff == ST_SETTLE && wd_done))) begin
                intr_start <= 1'b1;
                event_code_reg <= nxt_code;
                event_code_reg_two <= nxt_code;
            end
        end
    end

    // module clock enables and register clears
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mod_clk_en <= '1;
            timer_start_clr <= 1'b0;
            adc_regs_reset <= 1'b0;
            timer_regs_reset <= 1'b0;
            serial_pins_reset <= 1'b0;
        end else begin
            mod_clk_en[pdmc_pkg::MOD_SERIAL] <=
                !ctrl_ff[pdmc_pkg::SERIAL_STOP_BIT] && cpu_clk_en;
            mod_clk_en[pdmc_pkg::MOD_RTC] <= !ctrl_ff[pdmc_pkg::RTC_STOP_BIT];
            mod_clk_en[pdmc_pkg::MOD_TIMER] <= !ctrl_ff[pdmc_pkg::TIMER_STOP_BIT] &&
                (state_ff != ST_STANDBY || timer_on_rtc_clk);
            mod_clk_en[pdmc_pkg::MOD_FIFO_SERIAL] <=
                !ctrl2_ff[pdmc_pkg::FIFO_SERIAL_STOP_BIT] && cpu_clk_en;
            mod_clk_en[pdmc_pkg::MOD_ADC] <= !ctrl2_ff[pdmc_pkg::ADC_STOP_BIT] && cpu_clk_en;
            mod_clk_en[pdmc_pkg::MOD_DAC] <= !ctrl2_ff[pdmc_pkg::DAC_STOP_BIT] && cpu_clk_en;
            mod_clk_en[pdmc_pkg::MOD_DMA] <= !ctrl2_ff[pdmc_pkg::DMA_STOP_BIT] && cpu_clk_en;
            mod_clk_en[pdmc_pkg::MOD_BREAK] <= !ctrl2_ff[pdmc_pkg::BREAK_STOP_BIT] && cpu_clk_en;
            timer_start_clr <= (state_ff == ST_STANDBY);
            adc_regs_reset <= (state_ff == ST_STANDBY) ||
                              ctrl2_ff[pdmc_pkg::ADC_STOP_BIT];
            timer_regs_reset <= ctrl_ff[pdmc_pkg::TIMER_STOP_BIT];
            serial_pins_reset <= ctrl_ff[pdmc_pkg::SERIAL_STOP_BIT];
        end
    end

    // read back
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            standby_control_reg <= pdmc_pkg::CTRL_RESET;
            standby_control_reg_two <= pdmc_pkg::CTRL_RESET;
            wdog_counter <= pdmc_pkg::WDOG_RESET;
        end else begin
            standby_control_reg <= ctrl_ff;
            standby_control_reg_two <= ctrl2_ff;
            wdog_counter <= wd_count;
        end
    end

    AST_SLEEP_PINS: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_SLEEP && !pin_reset) |=> (state_out_upper && !state_out_lower))
        else $error("sleep pin code wrong");
    AST_STANDBY_SELECT_BIT_PINS: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_STANDBY && !pin_reset) |=> (!state_out_upper && state_out_lower
        && !clock_out_en)) else $error("standby pin code wrong");
    AST_SLEEP_ENTRY: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_RUN && sleep_exec && !ctrl_ff[pdmc_pkg::STANDBY_SELECT_BIT_BIT] && !pin_reset)
        |=> state_ff == ST_SLEEP) else $error("sleep not entered");
    AST_STANDBY_SELECT_BIT_ENTRY: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_RUN && sleep_exec && ctrl_ff[pdmc_pkg::STANDBY_SELECT_BIT_BIT] && !pin_reset)
        |=> state_ff == ST_STANDBY ##1 !cpu_clk_en) else $error("standby missed");
    AST_SLEEP_EXIT: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_SLEEP && any_int && !pin_reset) |=> (intr_start &&
        event_code_reg == event_code_reg_two)) else $error("sleep exit wrong");
    AST_RESET_EXIT: assert property (@(posedge clk_sys) disable iff (rst)
        pin_reset |=> (state_ff == ST_RUN && ctrl2_ff == 8'h00)) else $error("reset exit");
    AST_SETTLE_WAIT: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_SETTLE && !wd_done) |=> !intr_start) else $error("early wake");
    AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
        (standby_control_reg_two[0] == 1'b0 && standby_control_reg[6:5] == 2'h0))
        else $error("reserved bit set");
    AST_ADC_RESET: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl2_ff[pdmc_pkg::ADC_STOP_BIT] |=> adc_regs_reset) else $error("adc reset");
    AST_BLOCK_IGNORED: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_STANDBY && standby_select_bit_wake && cpu_block_bit && !pin_reset)
        |=> state_ff == ST_SETTLE) else $error("wake refused under block bit");
    AST_COUNT_STOP: assert property (@(posedge clk_sys) disable iff (rst)
        (state_ff == ST_RUN && !ctrl_ff[pdmc_pkg::STANDBY_SELECT_BIT_BIT] && !wdog_wr) |=> $stable(wd_count))
        else $error("watchdog counter kept running");
endmodule : pdmc_top

// file: inc/pdmc_pkg.sv
// Purpose: shared constants for the power-down mode controller
// Assumes: 8-bit standby control registers, 100 MHz system clock
// Notes: bit positions follow the two standby control registers
package pdmc_pkg;
    // standby_control_reg fields
    localparam int STANDBY_SELECT_BIT_BIT = 7;
    localparam int XTAL_BIT = 4;
    localparam int TIMER_STOP_BIT = 2;
    localparam int RTC_STOP_BIT = 1;
    localparam int SERIAL_STOP_BIT = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h97;
    // standby_control_reg_two fields
    localparam int MDCHG_BIT = 6;
    localparam int BREAK_STOP_BIT = 5;
    localparam int DMA_STOP_BIT = 4;
    localparam int DAC_STOP_BIT = 3;
    localparam int ADC_STOP_BIT = 2;
    localparam int FIFO_SERIAL_STOP_BIT = 1;
    localparam logic [7:0] CTRL2_WMASK = 8'h7e;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // gated module clock enables, one per module-stop bit
    localparam int NUM_MOD = 8;
    localparam int MOD_SERIAL = 0;
    localparam int MOD_RTC = 1;
    localparam int MOD_TIMER = 2;
    localparam int MOD_FIFO_SERIAL = 3;
    localparam int MOD_ADC = 4;
    localparam int MOD_DAC = 5;
    localparam int MOD_DMA = 6;
    localparam int MOD_BREAK = 7;
    // watchdog
    localparam logic [7:0] WDOG_WAKE_COUNT = 8'h80;
    localparam logic [7:0] WDOG_RESET = 8'h00;
    localparam logic [2:0] WDOG_CKS_RESET = 3'h0;
    localparam int WDOG_PRESCALE_W = 12;
    // state pin codes {upper, lower}
    localparam logic [1:0] PINS_RESET = 2'h3;
    localparam logic [1:0] PINS_SLEEP = 2'h2;
    localparam logic [1:0] PINS_STANDBY = 2'h1;
    localparam logic [1:0] PINS_NORMAL = 2'h0;
    // event codes
    localparam logic [11:0] EVT_NMI = 12'h1c0;
    localparam logic [11:0] EVT_IRL_BASE = 12'h200;
    localparam logic [11:0] EVT_IRQ_BASE = 12'h600;
    localparam logic [11:0] EVT_PERIPH = 12'h400;
    localparam logic [11:0] EVT_STEP = 12'h020;
    localparam logic [3:0] IRL_NONE = 4'hf;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_STANDBY = 2'b10,
        ST_SETTLE = 2'b11
    } pdmc_state_t;
endpackage : pdmc_pkg

// file: logic/pdmc_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock domain clk_sys
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module pdmc_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_ff <= INIT;
            q <= INIT;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : pdmc_sync

// file: logic/pdmc_wdog.sv
// Purpose: settling-time watchdog counter
// Assumes: counter preloaded by software before standby
// Notes: counts up from load value; done when bit 7 reaches 1
`timescale 1ns/1ps
module pdmc_wdog (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic [2:0] clk_sel,
    // status
    output logic [7:0] count_ff,
    output logic done
);
    logic [pdmc_pkg::WDOG_PRESCALE_W-1:0] pre_ff;
    logic tick;
    // divide by 2^(2*cks+1) for cks 0 to 5; cks 6 and 7 both divide by 2^12
    function automatic logic tick_of(input logic [11:0] p, input logic [2:0] s);
        logic [11:0] m;
        m = 12'((12'h002 << {s, 1'b0}) - 12'h001);
        tick_of = ((p & m) == m);
    endfunction : tick_of
    assign tick = tick_of(pre_ff, clk_sel);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_ff <= '0;
        end else if (run) begin
            pre_ff <= pre_ff + 12'h001;
        end else begin
            pre_ff <= '0;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_ff <= pdmc_pkg::WDOG_RESET;
        end else if (load) begin
            count_ff <= load_val;
        end else if (run && tick) begin // wraps past ffh
            count_ff <= count_ff + 8'h01;
        end
    end
    assign done = (count_ff >= pdmc_pkg::WDOG_WAKE_COUNT);
endmodule : pdmc_wdog

// file: bench/pdmc_partner.sv
// Purpose: system logic beside the state pins: wake and reset pins
// Assumes: pins sampled on clk_sys
// Notes: standby wake is raised only once the standby code has shown
`timescale 1ns/1ps
module pdmc_partner #(
    parameter int HOLD = 6
) (
    // clock
    input wire logic clk_sys,
    // state pins
    input wire logic state_out_upper,
    input wire logic state_out_lower,
    // bench commands
    input wire logic wake_en,
    input wire logic nmi_req,
    input wire logic por_req,
    input wire logic man_req,
    // towards the device
    output logic nmi_pin,
    output logic poweron_reset_pin_n,
    output logic manual_reset_pin_n
);
    logic standby_seen = 1'b0;
    int por_cnt = 0;
    int man_cnt = 0;
    always_ff @(posedge clk_sys) begin
        if ({state_out_upper, state_out_lower} == 2'b01) begin
            standby_seen <= 1'b1;
        end else if ({state_out_upper, state_out_lower} == 2'b00) begin
            standby_seen <= 1'b0;
        end
    end
    // wake_en wake only after the standby code
    assign nmi_pin = nmi_req | (wake_en & standby_seen);
    // reset pins stay low until the oscillator would have settled
    always_ff @(posedge clk_sys) begin
        por_cnt <= por_req ? HOLD : (por_cnt > 0 ? por_cnt - 1 : 0);
        man_cnt <= man_req ? HOLD : (man_cnt > 0 ? man_cnt - 1 : 0);
    end
    assign poweron_reset_pin_n = !(por_req || por_cnt > 0);
    assign manual_reset_pin_n = !(man_req || man_cnt > 0);
endmodule : pdmc_partner

// file: bench/tb_top.sv
// Purpose: self-checking bench for the power-down mode controller
// Assumes: inputs driven 1 ns after the rising edge
// Notes: random sources from a fixed seed plus hand-picked corners
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, rst, sleep_exec, cpu_block_bit, ctrl_wr, ctrl2_wr, wdog_wr, seen;
    logic nmi_pin, periph_irq, rtc_irq, timer_irq, timer_on_rtc_clk, por_n, man_n;
    logic wake_en, nmi_req, por_req, man_req, upper, lower, cpu_halt, cpu_clk_en;
    logic clock_out_en, intr_start, tstart_clr, adc_rst, tmr_rst, ser_rst;
    logic [3:0] interrupt_mask_field, encoded_level_lines;
    logic [7:0] ctrl_wdata, ctrl2_wdata, wdog_wdata, ctrl_rb, ctrl2_rb, wdog_counter;
    logic [7:0] mod_clk_en, a, b;
    logic [2:0] wdog_clock_select;
    logic [4:0] external_irq_lines;
    logic [11:0] evt, evt2;
    int fail_count = 0, comparisons = 0, cycles = 0, idx;
    int src_t[8] = '{3, 4, 5, 5, 1, 1, 2, 0};
    int idx_t[8] = '{0, 0, 0, 0, 5, 6, 0, 0};
    logic exp_w[8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

    pdmc_partner PARTNER (.clk_sys(clk_sys), .state_out_upper(upper),
        .state_out_lower(lower), .wake_en(wake_en), .nmi_req(nmi_req), .por_req(por_req),
        .man_req(man_req), .nmi_pin(nmi_pin), .poweron_reset_pin_n(por_n),
        .manual_reset_pin_n(man_n));

    pdmc_top DUT (.clk_sys(clk_sys), .rst(rst), .poweron_reset_pin_n(por_n),
        .manual_reset_pin_n(man_n), .sleep_exec(sleep_exec), .cpu_block_bit(cpu_block_bit),
        .interrupt_mask_field(interrupt_mask_field), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .ctrl2_wr(ctrl2_wr), .ctrl2_wdata(ctrl2_wdata),
        .wdog_wr(wdog_wr), .wdog_wdata(wdog_wdata), .wdog_clock_select(wdog_clock_select),
        .nmi_pin(nmi_pin), .encoded_level_lines(encoded_level_lines),
        .external_irq_lines(external_irq_lines), .periph_irq(periph_irq),
        .rtc_irq(rtc_irq), .timer_irq(timer_irq), .timer_on_rtc_clk(timer_on_rtc_clk),
        .standby_control_reg(ctrl_rb), .standby_control_reg_two(ctrl2_rb),
        .wdog_counter(wdog_counter), .state_out_upper(upper), .state_out_lower(lower),
        .cpu_halt(cpu_halt), .cpu_clk_en(cpu_clk_en), .clock_out_en(clock_out_en),
        .intr_start(intr_start), .event_code_reg(evt), .event_code_reg_two(evt2),
        .mod_clk_en(mod_clk_en), .timer_start_clr(tstart_clr), .adc_regs_reset(adc_rst),
        .timer_regs_reset(tmr_rst), .serial_pins_reset(ser_rst));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic print_verdict;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic check_val(input string what, input logic [11:0] exp, input logic [11:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_pins(input string what, input logic [1:0] exp);
        check_val(what, {10'h000, exp}, {10'h000, upper, lower});
    endtask : check_pins

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : tick

    // kind 0 waits for the interrupt pulse, kind 1 for a pin code
    task automatic wait_for(input int kind, input logic [1:0] p, input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            tick(1);
            seen = kind == 0 ? intr_start === 1'b1 : {upper, lower} === p;
        end
    endtask : wait_for

    task automatic wr_reg(input int sel, input logic [7:0] d);
        ctrl_wdata = d;
        ctrl2_wdata = d;
        wdog_wdata = d;
        ctrl_wr = sel == 0;
        ctrl2_wr = sel == 1;
        wdog_wr = sel == 2;
        tick(1);
        {ctrl_wr, ctrl2_wr, wdog_wr} = 3'h0;
        tick(1);
    endtask : wr_reg

    task automatic pulse_sleep;
        sleep_exec = 1'b1;
        tick(1);
        sleep_exec = 1'b0;
        tick(2);
    endtask : pulse_sleep

    task automatic set_src(input int src, input int n, input logic on);
        nmi_req = on && src == 0;
        encoded_level_lines = (on && src == 1) ? ~4'(n) : 4'hf;
        external_irq_lines = (on && src == 2) ? 5'(1 << n) : 5'h00;
        periph_irq = on && src == 3;
        rtc_irq = on && src == 4;
        timer_irq = on && src == 5;
    endtask : set_src

    function automatic logic [7:0] exp_clk(input logic [7:0] c, input logic [7:0] c2);
        exp_clk = ~{c2[5:1], c[2:0]};
    endfunction : exp_clk

    function automatic logic [11:0] exp_code(input int src, input int n);
        case (src)
            0: exp_code = 12'h1c0;
            1: exp_code = 12'h200 + 12'(n) * 12'h020;
            2: exp_code = 12'h600 + 12'(n) * 12'h020;
            default: exp_code = 12'h400;
        endcase
    endfunction : exp_code

    initial begin
        void'($urandom(32'h52fa21c0));
        {rst, sleep_exec, cpu_block_bit, wake_en, por_req, man_req, timer_on_rtc_clk} = 7'h40;
        {ctrl_wr, ctrl2_wr, wdog_wr} = 3'h0;
        {ctrl_wdata, ctrl2_wdata, wdog_wdata} = 24'h000000;
        interrupt_mask_field = 4'h0;
        wdog_clock_select = 3'h0;
        set_src(0, 0, 1'b0);
        tick(4);
        check_pins("reset pins", 2'b11);
        rst = 1'b0;
        tick(2);
        check_pins("normal pins", 2'b00);
        for (int i = 0; i < 12; i++) begin
            a = i == 0 ? 8'hff : 8'($urandom) & 8'h7f;
            b = i == 0 ? 8'hff : 8'($urandom);
            wr_reg(0, a);
            wr_reg(1, b);
            tick(3);
            check_val("ctrl", {4'h0, a & 8'h97}, {4'h0, ctrl_rb});
            check_val("ctrl2", {4'h0, b & 8'h7e}, {4'h0, ctrl2_rb});
            check_val("clk en", {4'h0, exp_clk(a, b)}, {4'h0, mod_clk_en});
            check_val("adc reset", {11'h0, b[2]}, {11'h0, adc_rst});
            check_val("timer reset", {11'h0, a[2]}, {11'h0, tmr_rst});
            check_val("serial reset", {11'h0, a[0]}, {11'h0, ser_rst});
        end
        wr_reg(0, 8'h00);
        wr_reg(1, 8'h00);
        tick(3);
        check_val("clk release", 12'h0ff, {4'h0, mod_clk_en});
        for (int s = 0; s < 4; s++) begin
            idx = s == 1 ? 1 + $urandom_range(14) : $urandom_range(4);
            cpu_block_bit = 1'($urandom);
            pulse_sleep();
            check_pins("sleep pins", 2'b10);
            check_val("halt", 12'h1, {11'h0, cpu_halt});
            check_val("clk out", 12'h1, {11'h0, clock_out_en});
            set_src(s, idx, 1'b1);
            wait_for(0, 2'b00, 20);
            check_val("sleep wake", 12'h1, {11'h0, seen});
            check_val("code", exp_code(s, idx), evt);
            check_val("code2", exp_code(s, idx), evt2);
            tick(1);
            set_src(0, 0, 1'b0);
            check_pins("run pins", 2'b00);
            tick(4);
        end
        interrupt_mask_field = 4'h5;
        for (int k = 0; k < 8; k++) begin
            timer_on_rtc_clk = k == 3;
            idx = k == 6 ? $urandom_range(4) : idx_t[k];
            wr_reg(2, 8'h7c);
            check_val("wdog count", 12'h07c, {4'h0, wdog_counter});
            wr_reg(0, 8'h80);
            pulse_sleep();
            check_pins("standby pins", 2'b01);
            check_val("cpu clk", 12'h0, {11'h0, cpu_clk_en});
            check_val("clk out", 12'h0, {11'h0, clock_out_en});
            check_val("timer start clr", 12'h1, {11'h0, tstart_clr});
            cpu_block_bit = 1'b1;
            set_src(src_t[k], idx, 1'b1);
            wait_for(0, 2'b00, 60);
            check_val("standby wake", {11'h0, exp_w[k]}, {11'h0, seen});
            if (!seen) begin
                wake_en = 1'b1;
                wait_for(0, 2'b00, 60);
                check_val("nmi code", 12'h1c0, evt);
            end else begin
                check_val("code", exp_code(src_t[k], idx), evt2);
            end
            wr_reg(0, 8'h00);
            check_pins("run pins", 2'b00);
            set_src(0, 0, 1'b0);
            wake_en = 1'b0;
            tick(4);
        end
        wr_reg(2, 8'h7c);
        wr_reg(0, 8'h80);
        pulse_sleep();
        set_src(0, 0, 1'b1);
        wait_for(0, 2'b00, 60);
        set_src(0, 0, 1'b0);
        wait_for(1, 2'b01, 600);
        check_val("standby again", 12'h1, {11'h0, seen});
        set_src(0, 0, 1'b1);
        wait_for(0, 2'b00, 60);
        wr_reg(0, 8'h00);
        set_src(0, 0, 1'b0);
        for (int r = 0; r < 2; r++) begin
            wr_reg(2, 8'h00);
            wr_reg(0, r == 1 ? 8'h87 : 8'h07);
            pulse_sleep();
            por_req = r == 1;
            man_req = r == 0;
            tick(1);
            {por_req, man_req} = 2'b00;
            wait_for(1, 2'b11, 10);
            check_val("reset seen", 12'h1, {11'h0, seen});
            wait_for(1, 2'b00, 40);
            check_val("reset left", 12'h1, {11'h0, seen});
            tick(2);
            check_val("ctrl cleared", 12'h0, {4'h0, ctrl_rb});
            check_val("clk after reset", 12'h0ff, {4'h0, mod_clk_en});
        end
        print_verdict();
    end
endmodule : tb_top
